/* File: hw/tcfa_pkg.sv */
package tcfa_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TRANSMIT_CONFIGURATION_OFS = 8'h70;
    localparam logic [7:0] HARDWARE_CONFIGURATION_OFS = 8'h74;

    // ------------------------------------------------------------
    // Transmit configuration fields
    // ------------------------------------------------------------
    localparam int TXC_STOP_BIT         = 0;
    localparam int TXC_ON_BIT           = 1;
    localparam int TXC_SAO_BIT          = 2;
    localparam int TXC_DFLUSH_BIT       = 14;
    localparam int TXC_SFLUSH_BIT       = 15;

    // ------------------------------------------------------------
    // Hardware configuration fields
    // ------------------------------------------------------------
    localparam int HWC_SIZE_LSB         = 16;
    localparam int HWC_MUST_ONE_BIT     = 20;
    localparam int HWC_STRAP_BIT        = 24;
    localparam logic [3:0] HWC_SIZE_RST = 4'h5;
    localparam logic [3:0] HWC_SIZE_MAX = 4'he;

    // ------------------------------------------------------------
    // Buffer allocation, in bytes
    // ------------------------------------------------------------
    localparam logic [14:0] ALLOC_UNIT  = 15'h0400;
    localparam logic [14:0] TXS_BYTES   = 15'h0200;
    localparam logic [15:0] TOTAL_BYTES = 16'h4000;
    localparam int RXS_DIV_SHIFT        = 4;
    localparam logic [14:0] RXD_GUARD   = 15'h0010;

    // ------------------------------------------------------------
    // Buffer lengths after reset, matching the reset size of five
    // ------------------------------------------------------------
    localparam logic [14:0] TXD_LEN_RST = 15'h1200;
    localparam logic [14:0] TXS_LEN_RST = 15'h0200;
    localparam logic [14:0] RXD_LEN_RST = 15'h2940;
    localparam logic [14:0] RXS_LEN_RST = 15'h02c0;

endpackage : tcfa_pkg

/* File: hw/tcfa_alloc.sv */
`timescale 1ns/1ps
// Splits the shared packet buffer between transmit and receive FIFOs
module tcfa_alloc (
    // Size selection in kilobytes
    input  wire logic [3:0]  size_kb,
    // Derived lengths in bytes
    output logic      [14:0] tx_data_len,
    output logic      [14:0] tx_stat_len,
    output logic      [14:0] rx_data_len,
    output logic      [14:0] rx_stat_len,
    output logic      [14:0] rx_full_lvl
);
    logic [14:0] tx_total;
    logic [14:0] rx_total;

    // Transmit share; status part is fixed, data gets the rest
    always_comb begin
        tx_total    = 15'(size_kb * tcfa_pkg::ALLOC_UNIT);
        tx_stat_len = tcfa_pkg::TXS_BYTES;
        tx_data_len = tx_total - tcfa_pkg::TXS_BYTES;
        rx_total    = 15'(tcfa_pkg::TOTAL_BYTES - {1'b0, tx_total});
        rx_stat_len = rx_total >> tcfa_pkg::RXS_DIV_SHIFT;
        rx_data_len = rx_total - rx_stat_len;
        rx_full_lvl = rx_data_len - tcfa_pkg::RXD_GUARD;
    end
endmodule : tcfa_alloc

/* File: hw/tcfa_regs.sv */
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
// Function
// - Writing one to status flush clears transmit status pointers; bit self-clears.
// - Writing one to data flush clears transmit data pointers; bit self-clears.
// - Overrun allow zero: suspend transmission while status FIFO full.
// - Overrun allow one: keep transmitting with full status FIFO.
// - Status full interrupt raised regardless of overrun allow.
// - Enable bit set lets queued transmit data go out.
// - Enable clears itself once stop has taken effect and transmitter halted.
// - Stop request finishes current frame, halts, then clears itself.
// - Writes to stop request ignored while it reads one.
// - Read-only bit reports the sampled crossover strap level.
// - Size field sets transmit allocation in 1 KB steps to 14 KB, reset 5.
// - Transmit status FIFO fixed 512 bytes; data FIFO gets the rest.
// - Transmit data FIFO holds commands and payload together.
// - Receive FIFOs share what remains of the 16 KB buffer.
// - Receive status FIFO takes one sixteenth; data takes the rest.
// - Receive data FIFO reports full with four double words free.
module tcfa_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Transmit engine and receive data FIFO status
    input  wire logic        tx_frame_busy,
    input  wire logic        tx_stat_full,
    input  wire logic [14:0] rx_data_used,
    // Strap level
    input  wire logic        crossover_strap,
    // Transmit engine control
    output logic             tx_run,
    output logic             tx_stat_ptr_clr,
    output logic             tx_data_ptr_clr,
    output logic             tx_stat_full_irq,
    output logic             must_be_one,
    // Buffer allocation
    output logic      [14:0] tx_data_len,
    output logic      [14:0] tx_stat_len,
    output logic      [14:0] rx_data_len,
    output logic      [14:0] rx_stat_len,
    output logic             rx_data_full
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        tx_on;
        logic        stop_req;
        logic        sao;
        logic        run;
        logic        sflush;
        logic        dflush;
        logic        sfull_irq;
        logic        must_one;
        logic [3:0]  size;
        logic        strap;
        logic        strap_done;
        logic [14:0] txd_len;
        logic [14:0] txs_len;
        logic [14:0] rxd_len;
        logic [14:0] rxs_len;
        logic        rx_full;
    } tcfa_state_s;

    tcfa_state_s st_ff;
    tcfa_state_s nxt_st;

    logic [14:0] a_txd;
    logic [14:0] a_txs;
    logic [14:0] a_rxd;
    logic [14:0] a_rxs;
    logic [14:0] a_full;
    logic        wr_tx;
    logic        wr_hw;
    logic        halted;

    // ------------------------------------------------------------
    // Allocation arithmetic
    // ------------------------------------------------------------
    tcfa_alloc u_alloc (
        .size_kb     (st_ff.size),
        .tx_data_len (a_txd),
        .tx_stat_len (a_txs),
        .rx_data_len (a_rxd),
        .rx_stat_len (a_rxs),
        .rx_full_lvl (a_full)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.sflush = 1'b0;
        nxt_st.dflush = 1'b0;
        wr_tx = 1'b0;
        wr_hw = 1'b0;
        // Stop takes effect only between frames
        halted = st_ff.stop_req && !tx_frame_busy;
        // One wait cycle, then acknowledge; ack drops waitrequest
        if ((avs_read || avs_write) && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            if (avs_address == tcfa_pkg::TRANSMIT_CONFIGURATION_OFS) begin
                nxt_st.rdata[tcfa_pkg::TXC_STOP_BIT] = st_ff.stop_req;
                nxt_st.rdata[tcfa_pkg::TXC_ON_BIT]   = st_ff.tx_on;
                nxt_st.rdata[tcfa_pkg::TXC_SAO_BIT]  = st_ff.sao;
                wr_tx = avs_write;
            end else if (avs_address == tcfa_pkg::HARDWARE_CONFIGURATION_OFS) begin
                nxt_st.rdata[tcfa_pkg::HWC_STRAP_BIT]    = st_ff.strap;
                nxt_st.rdata[tcfa_pkg::HWC_MUST_ONE_BIT] = st_ff.must_one;
                nxt_st.rdata[tcfa_pkg::HWC_SIZE_LSB +: 4] = st_ff.size;
                wr_hw = avs_write;
            end
        end
        // Transmit configuration write; self-clearing bits pulse once
        if (wr_tx && avs_byteenable[0]) begin
            nxt_st.sao   = avs_writedata[tcfa_pkg::TXC_SAO_BIT];
            nxt_st.tx_on = avs_writedata[tcfa_pkg::TXC_ON_BIT];
            if (!st_ff.stop_req) begin
                nxt_st.stop_req = avs_writedata[tcfa_pkg::TXC_STOP_BIT];
            end
        end
        if (wr_tx && avs_byteenable[1]) begin
            nxt_st.sflush = avs_writedata[tcfa_pkg::TXC_SFLUSH_BIT];
            nxt_st.dflush = avs_writedata[tcfa_pkg::TXC_DFLUSH_BIT];
        end
        // Halt wins over a same-cycle write: the stop already completed
        if (halted) begin
            nxt_st.stop_req = 1'b0;
            nxt_st.tx_on = 1'b0;
        end
        // Hardware configuration write; oversize values are clamped
        if (wr_hw && avs_byteenable[2]) begin
            nxt_st.must_one = avs_writedata[tcfa_pkg::HWC_MUST_ONE_BIT];
            if (avs_writedata[tcfa_pkg::HWC_SIZE_LSB +: 4] > tcfa_pkg::HWC_SIZE_MAX) begin
                nxt_st.size = tcfa_pkg::HWC_SIZE_MAX;
            end else begin
                nxt_st.size = avs_writedata[tcfa_pkg::HWC_SIZE_LSB +: 4];
            end
        end
        // Strap caught once, the first clock after reset release
        if (!st_ff.strap_done) begin
            nxt_st.strap = crossover_strap;
            nxt_st.strap_done = 1'b1;
        end
        // Transmission gate; overrun allow bypasses the full check
        nxt_st.run = nxt_st.tx_on && (nxt_st.sao || !tx_stat_full);
        nxt_st.sfull_irq = tx_stat_full;
        nxt_st.txd_len = a_txd;
        nxt_st.txs_len = a_txs;
        nxt_st.rxd_len = a_rxd;
        nxt_st.rxs_len = a_rxs;
        nxt_st.rx_full = rx_data_used >= a_full;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.size <= tcfa_pkg::HWC_SIZE_RST;
            st_ff.must_one <= 1'b0;
            st_ff.txd_len <= tcfa_pkg::TXD_LEN_RST;
            st_ff.txs_len <= tcfa_pkg::TXS_LEN_RST;
            st_ff.rxd_len <= tcfa_pkg::RXD_LEN_RST;
            st_ff.rxs_len <= tcfa_pkg::RXS_LEN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign avs_readdata     = st_ff.rdata;
    assign avs_waitrequest  = !st_ff.ack;
    assign tx_run           = st_ff.run;
    assign tx_stat_ptr_clr  = st_ff.sflush;
    assign tx_data_ptr_clr  = st_ff.dflush;
    assign tx_stat_full_irq = st_ff.sfull_irq;
    assign must_be_one      = st_ff.must_one;
    assign tx_data_len      = st_ff.txd_len;
    assign tx_stat_len      = st_ff.txs_len;
    assign rx_data_len      = st_ff.rxd_len;
    assign rx_stat_len      = st_ff.rxs_len;
    assign rx_data_full     = st_ff.rx_full;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Stop write seen at the edge that takes the request, not the answer edge
    sequence s_stop_write;
        avs_write && !st_ff.ack && avs_address == tcfa_pkg::TRANSMIT_CONFIGURATION_OFS
            && avs_byteenable[0] && !st_ff.stop_req;
    endsequence

    // Pending stop, then the frame in flight finishes
    sequence s_frame_ends;
        st_ff.stop_req && tx_frame_busy ##1 !tx_frame_busy;
    endsequence

    AST_SFLUSH_PULSE: assert property (@(posedge clk) disable iff (!nrst)
        wr_tx && avs_byteenable[1] && avs_writedata[15] |=> tx_stat_ptr_clr ##1 !tx_stat_ptr_clr)
        else $error("status flush did not pulse once");
    AST_DFLUSH_PULSE: assert property (@(posedge clk) disable iff (!nrst)
        wr_tx && avs_byteenable[1] && avs_writedata[14] |=> tx_data_ptr_clr ##1 !tx_data_ptr_clr)
        else $error("data flush did not pulse once");
    AST_SUSPEND_FULL: assert property (@(posedge clk) disable iff (!nrst)
        tx_run && !st_ff.sao |-> $past(!tx_stat_full))
        else $error("transmitting with full status FIFO");
    AST_OVERRUN_RUN: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.sao && st_ff.tx_on && !halted && !wr_tx |=> tx_run)
        else $error("overrun allow did not keep transmitter running");
    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (!nrst)
        tx_stat_full |=> tx_stat_full_irq)
        else $error("status full irq missing");
    AST_HALT_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
        halted |=> !st_ff.tx_on && !st_ff.stop_req)
        else $error("halt did not clear enable and stop");
    AST_STOP_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.stop_req && tx_frame_busy |=> st_ff.stop_req)
        else $error("stop cleared during a frame");
    AST_STOP_SET: assert property (@(posedge clk) disable iff (!nrst)
        s_stop_write ##0 avs_writedata[0] |=> st_ff.stop_req || $past(halted))
        else $error("stop request write lost");
    AST_SIZE_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.size <= tcfa_pkg::HWC_SIZE_MAX)
        else $error("size field out of range");
    AST_READ_ACK: assert property (@(posedge clk) disable iff (!nrst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

    // Transmit gating and stop handshake
    AST_STOP_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
        wr_tx && avs_byteenable[0] && st_ff.stop_req && tx_frame_busy |=> st_ff.stop_req)
        else $error("stop request changed by a write while set");
    AST_RUN_NEEDS_ON: assert property (@(posedge clk) disable iff (!nrst)
        tx_run |-> st_ff.tx_on)
        else $error("transmitting while disabled");
    AST_ON_SENDS: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.tx_on && !st_ff.sao && !tx_stat_full && !halted && !wr_tx |=> tx_run)
        else $error("enabled transmitter not running");
    AST_FULL_BLOCKS: assert property (@(posedge clk) disable iff (!nrst)
        !st_ff.sao && tx_stat_full && !wr_tx |=> !tx_run)
        else $error("full status FIFO did not suspend transmission");
    AST_IRQ_DROPS: assert property (@(posedge clk) disable iff (!nrst)
        !tx_stat_full |=> !tx_stat_full_irq)
        else $error("status full irq without full status FIFO");
    AST_HALT_STOPS_RUN: assert property (@(posedge clk) disable iff (!nrst)
        halted |=> !tx_run)
        else $error("transmitter still running after halt");
    AST_STOP_AFTER_FRAME: assert property (@(posedge clk) disable iff (!nrst)
        s_frame_ends |=> !st_ff.stop_req && !st_ff.tx_on)
        else $error("stop not completed after the frame");

    // Flush pulses only come from a flush write
    AST_SFLUSH_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
        tx_stat_ptr_clr |-> $past(wr_tx && avs_byteenable[1]
            && avs_writedata[tcfa_pkg::TXC_SFLUSH_BIT]))
        else $error("status flush without a write");
    AST_DFLUSH_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
        tx_data_ptr_clr |-> $past(wr_tx && avs_byteenable[1]
            && avs_writedata[tcfa_pkg::TXC_DFLUSH_BIT]))
        else $error("data flush without a write");

    // Hardware configuration contents
    AST_STRAP_KEPT: assert property (@(posedge clk) disable iff (!nrst)
        st_ff.strap_done |=> $stable(st_ff.strap))
        else $error("strap level changed after capture");
    AST_STRAP_READ: assert property (@(posedge clk) disable iff (!nrst)
        !avs_waitrequest && $past(st_ff.strap_done)
            && $past(avs_address == tcfa_pkg::HARDWARE_CONFIGURATION_OFS)
            |-> avs_readdata[tcfa_pkg::HWC_STRAP_BIT] == st_ff.strap)
        else $error("strap bit read back wrong");
    AST_SIZE_TAKEN: assert property (@(posedge clk) disable iff (!nrst)
        wr_hw && avs_byteenable[2]
            && avs_writedata[tcfa_pkg::HWC_SIZE_LSB +: 4] <= tcfa_pkg::HWC_SIZE_MAX
            |=> st_ff.size == $past(avs_writedata[tcfa_pkg::HWC_SIZE_LSB +: 4]))
        else $error("size write not taken");
    AST_SIZE_CLAMP: assert property (@(posedge clk) disable iff (!nrst)
        wr_hw && avs_byteenable[2]
            && avs_writedata[tcfa_pkg::HWC_SIZE_LSB +: 4] > tcfa_pkg::HWC_SIZE_MAX
            |=> st_ff.size == tcfa_pkg::HWC_SIZE_MAX)
        else $error("oversize write not clamped");
    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        !avs_waitrequest |-> avs_readdata[31:25] == 7'h00 && avs_readdata[23:21] == 3'h0
            && avs_readdata[15:3] == 13'h0000)
        else $error("reserved bits read nonzero");

    // Buffer split; lengths follow the size field one cycle later
    AST_TX_SPLIT: assert property (@(posedge clk) disable iff (!nrst)
        tx_stat_len == tcfa_pkg::TXS_BYTES
            && tx_data_len + tx_stat_len == 15'($past(st_ff.size) * tcfa_pkg::ALLOC_UNIT))
        else $error("transmit split wrong");
    AST_RX_REST: assert property (@(posedge clk) disable iff (!nrst)
        {1'b0, rx_data_len} + {1'b0, rx_stat_len} + {1'b0, tx_data_len}
            + {1'b0, tx_stat_len} == tcfa_pkg::TOTAL_BYTES)
        else $error("receive share does not fill the buffer");
    AST_RXS_SIXTEENTH: assert property (@(posedge clk) disable iff (!nrst)
        (19'(rx_stat_len) << 4) == 19'(rx_data_len) + 19'(rx_stat_len))
        else $error("receive status share wrong");
    AST_FULL_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
        rx_data_full == ($past(rx_data_used) >= rx_data_len - tcfa_pkg::RXD_GUARD))
        else $error("receive full flag wrong");
endmodule : tcfa_regs

/* File: dv/tcfa_regs_tb.sv */
`timescale 1ns/1ps
module tcfa_regs_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tx_frame_busy = 1'b0;
    logic        tx_stat_full = 1'b0;
    logic [14:0] rx_data_used = 15'h0;
    logic        crossover_strap = 1'b1;
    logic        tx_run, tx_stat_ptr_clr, tx_data_ptr_clr, tx_stat_full_irq, must_be_one;
    logic [14:0] tx_data_len, tx_stat_len, rx_data_len, rx_stat_len;
    logic        rx_data_full;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          n_sclr = 0;
    int          n_dclr = 0;
    localparam logic [7:0] TXC_A = tcfa_pkg::TRANSMIT_CONFIGURATION_OFS;
    localparam logic [7:0] HWC_A = tcfa_pkg::HARDWARE_CONFIGURATION_OFS;

    tcfa_regs dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_frame_busy(tx_frame_busy), .tx_stat_full(tx_stat_full), .rx_data_used(rx_data_used),
        .crossover_strap(crossover_strap), .tx_run(tx_run), .tx_stat_ptr_clr(tx_stat_ptr_clr),
        .tx_data_ptr_clr(tx_data_ptr_clr), .tx_stat_full_irq(tx_stat_full_irq),
        .must_be_one(must_be_one), .tx_data_len(tx_data_len), .tx_stat_len(tx_stat_len),
        .rx_data_len(rx_data_len), .rx_stat_len(rx_stat_len), .rx_data_full(rx_data_full));

    // ------------------------------------------------------------
    // Clock, timeout and flush pulse counters
    // ------------------------------------------------------------
    always #10 clk = ~clk;
    // Pulses last one cycle, so they are counted rather than sampled
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_stat_ptr_clr === 1'b1) n_sclr <= n_sclr + 1;
        if (tx_data_ptr_clr === 1'b1) n_dclr <= n_dclr + 1;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        chk(exp, v);
    endtask : rd_chk

    // Lengths lag the size field by one cycle
    task automatic len_chk(input int s);
        int rx;
        rx = 16384 - s * 1024;
        tick(2);
        chk(32'(s * 1024 - 512), {17'h0, tx_data_len});
        chk(32'h200, {17'h0, tx_stat_len});
        chk(32'(rx - rx / 16), {17'h0, rx_data_len});
        chk(32'(rx / 16), {17'h0, rx_stat_len});
    endtask : len_chk

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        nrst <= 1'b1;
        rd_chk(TXC_A, 32'h0);
        rd_chk(HWC_A, 32'h0105_0000);
        chk(32'h0, {31'h0, must_be_one});
        len_chk(5);
        // All ones: reserved stay zero, size clamps to the largest setting
        bus_wr(HWC_A, 32'hffff_ffff, 4'hf);
        rd_chk(HWC_A, 32'h011e_0000);
        chk(32'h1, {31'h0, must_be_one});
        bus_wr(HWC_A, 32'h0, 4'h0);
        rd_chk(HWC_A, 32'h011e_0000);
        // Transmitter stays off here, and sizes start at two kilobytes
        for (int s = 2; s <= 14; s++) begin
            bus_wr(HWC_A, 32'(s) << 16 | 32'h0010_0000, 4'hf);
            rd_chk(HWC_A, 32'h0110_0000 | 32'(s) << 16);
            len_chk(s);
        end
        // Full threshold sits four double words below the data length
        rx_data_used <= 15'(1903);
        tick(3);
        chk(32'h0, {31'h0, rx_data_full});
        rx_data_used <= 15'(1904);
        tick(3);
        chk(32'h1, {31'h0, rx_data_full});
        // Unmapped place reads zero and ignores writes
        bus_wr(8'h78, 32'hffff_ffff, 4'hf);
        rd_chk(8'h78, 32'h0);
        // Flushes pulse once each and read back zero
        bus_wr(TXC_A, 32'h0000_8000, 4'hf);
        tick(1);
        chk(32'h1, 32'(n_sclr));
        chk(32'h0, 32'(n_dclr));
        bus_wr(TXC_A, 32'h0000_4000, 4'hf);
        tick(1);
        chk(32'h1, 32'(n_dclr));
        rd_chk(TXC_A, 32'h0);
        bus_wr(TXC_A, 32'hffff_3ffc, 4'hf);
        rd_chk(TXC_A, 32'h4);
        // Full status FIFO gates the transmitter only without overrun allow
        bus_wr(TXC_A, 32'h2, 4'hf);
        tick(1);
        chk(32'h1, {31'h0, tx_run});
        tx_stat_full <= 1'b1;
        tick(3);
        chk(32'h0, {31'h0, tx_run});
        chk(32'h1, {31'h0, tx_stat_full_irq});
        bus_wr(TXC_A, 32'h6, 4'hf);
        tick(2);
        chk(32'h1, {31'h0, tx_run});
        chk(32'h1, {31'h0, tx_stat_full_irq});
        tx_stat_full <= 1'b0;
        // Stop waits for the frame, ignores writes meanwhile, then clears both bits
        tx_frame_busy <= 1'b1;
        bus_wr(TXC_A, 32'h3, 4'hf);
        rd_chk(TXC_A, 32'h3);
        bus_wr(TXC_A, 32'h2, 4'hf);
        rd_chk(TXC_A, 32'h3);
        tx_frame_busy <= 1'b0;
        tick(3);
        rd_chk(TXC_A, 32'h0);
        chk(32'h0, {31'h0, tx_run});
        final_report();
    end
endmodule : tcfa_regs_tb
